// ==== common/ivmu_pkg.sv ====
// shared constants for the interrupt vector and mask unit
package ivmu_pkg;
  // register byte offsets on the avalon slave
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_VECBASE = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQMASK = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_VECTOR = 5'h14;
  // widths
  localparam int DATA_W = 32;
  localparam int BASE_W = 8;
  localparam int VADDR_W = 6;
  localparam int VEC_W = 16;
  localparam int MASK_W = 5;
  localparam int SRC_N = 6;
  // source positions in request, grant and status vectors
  localparam int SRC_RX = 0;
  localparam int SRC_TX = 1;
  localparam int SRC_TURN = 2;
  localparam int SRC_BIDIR = 3;
  localparam int SRC_TIMER = 4;
  localparam int SRC_NMI = 5;
  // direction bit of the configuration register, 1 = pin is output
  localparam int CFG_DIR_BIT = 0;
  // fixed vector addresses per source
  localparam logic [VADDR_W-1:0] VEC_RX = 6'h04;
  localparam logic [VADDR_W-1:0] VEC_TX = 6'h08;
  localparam logic [VADDR_W-1:0] VEC_TURN = 6'h0C;
  localparam logic [VADDR_W-1:0] VEC_BIDIR = 6'h10;
  localparam logic [VADDR_W-1:0] VEC_TIMER = 6'h14;
  localparam logic [VADDR_W-1:0] VEC_NMI = 6'h1C;
  // gap bits between base and vector address
  localparam logic [1:0] VEC_GAP = 2'h0;
  // reset values
  localparam logic [BASE_W-1:0] RST_VECBASE = 8'h00;
  localparam logic [MASK_W-1:0] RST_MASK = 5'h00;
  localparam logic RST_CFG_DIR = 1'b0;
  localparam logic [SRC_N-1:0] RST_STATUS = 6'h00;
  localparam logic [SRC_N-1:0] RST_IRQMASK = 6'h00;
  localparam logic [VEC_W-1:0] RST_VECTOR = 16'h0000;
endpackage

// ==== logic/vector_select.sv ====
// fixed priority pick among the gated requests
`timescale 1ns/1ps
module vector_select
  import ivmu_pkg::*;
(
  input wire logic [ivmu_pkg::SRC_N-1:0] req,
  output logic [ivmu_pkg::SRC_N-1:0] grant,
  output logic [ivmu_pkg::VADDR_W-1:0] vecAddr,
  output logic valid
);

  // nmi beats everything, then receiver down to timer
  always_comb begin
    grant = '0;
    vecAddr = '0;
    valid = |req;
    if (req[SRC_NMI]) begin
      grant[SRC_NMI] = 1'b1;
      vecAddr = VEC_NMI;
    end else if (req[SRC_RX]) begin
      grant[SRC_RX] = 1'b1;
      vecAddr = VEC_RX;
    end else if (req[SRC_TX]) begin
      grant[SRC_TX] = 1'b1;
      vecAddr = VEC_TX;
    end else if (req[SRC_TURN]) begin
      grant[SRC_TURN] = 1'b1;
      vecAddr = VEC_TURN;
    end else if (req[SRC_BIDIR]) begin
      grant[SRC_BIDIR] = 1'b1;
      vecAddr = VEC_BIDIR;
    end else if (req[SRC_TIMER]) begin
      grant[SRC_TIMER] = 1'b1;
      vecAddr = VEC_TIMER;
    end
  end

endmodule

// ==== logic/interrupt_vector_mask_unit.sv ====
// interrupt vectoring, masking and bidirectional pin control
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
// Behaviour
// - accepted vector is base register above, source vector address below
// - receiver 000100, transmitter 001000, nmi 011100
// - line turn-around 001100, bidirectional pin 010000, timer 010100
// - mask bit high blocks its source; bit 0 receiver, bit 4 timer
// - pin as output is driven from mask bit 3
// - pin as input is masked by mask bit 3
module interrupt_vector_mask_unit
  import ivmu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ivmu_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [ivmu_pkg::DATA_W-1:0] writedata,
  output logic [ivmu_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic rxReq,
  input wire logic txReq,
  input wire logic turnReq,
  input wire logic timerReq,
  input wire logic nmiReq,
  input wire logic bidirIrqIn,
  output logic bidirIrqOut,
  output logic bidirIrqOe,
  output logic irqPending,
  input wire logic intAck,
  output logic [ivmu_pkg::VEC_W-1:0] vectorOut,
  output logic irq
);

  logic [BASE_W-1:0] vecBase_reg, vecBase_next;
  logic [MASK_W-1:0] mask_reg, mask_next;
  logic cfgDir_reg, cfgDir_next;
  logic [SRC_N-1:0] status_reg, status_next;
  logic [SRC_N-1:0] irqMask_reg, irqMask_next;
  logic [VEC_W-1:0] vector_reg, vector_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic resp_reg, resp_next;
  logic pinMeta_reg, pinSync_reg;
  logic [SRC_N-1:0] gatedReq;
  logic [SRC_N-1:0] grant;
  logic [VADDR_W-1:0] selAddr;
  logic selValid;
  logic accept;
  logic wrDone, rdDone;

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser: only the second stage feeds logic
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_reg <= 1'b0;
      pinSync_reg <= 1'b0;
    end else begin
      pinMeta_reg <= bidirIrqIn;
      pinSync_reg <= pinMeta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // source gating; the pin is no source while we drive it ourselves
  always_comb begin
    gatedReq = '0;
    gatedReq[SRC_RX] = rxReq & ~mask_reg[SRC_RX];
    gatedReq[SRC_TX] = txReq & ~mask_reg[SRC_TX];
    gatedReq[SRC_TURN] = turnReq & ~mask_reg[SRC_TURN];
    gatedReq[SRC_BIDIR] = pinSync_reg & ~cfgDir_reg
                          & ~mask_reg[SRC_BIDIR];
    gatedReq[SRC_TIMER] = timerReq & ~mask_reg[SRC_TIMER];
    gatedReq[SRC_NMI] = nmiReq;
  end

  vector_select u_select (
    .req(gatedReq),
    .grant(grant),
    .vecAddr(selAddr),
    .valid(selValid)
  );

  // core sees a level; it acknowledges with a one-cycle pulse
  assign irqPending = selValid;
  assign accept = intAck & selValid;

  //////////////////////////////////////////////////////////////////////////
  // avalon slave: exactly one wait cycle on every access
  assign waitrequest = (read | write) & ~resp_reg;
  assign wrDone = write & resp_reg;
  assign rdDone = read & resp_reg;
  assign readdata = rdata_reg;

  always_comb begin
    resp_next = (read | write) & ~resp_reg;
    rdata_next = rdata_reg;
    if (read & ~resp_reg) begin
      // unmapped offsets answer zero
      case (address)
        OFS_VECBASE: rdata_next = DATA_W'(vecBase_reg);
        OFS_MASK: rdata_next = DATA_W'(mask_reg);
        OFS_CONFIG: rdata_next = DATA_W'(cfgDir_reg);
        OFS_STATUS: rdata_next = DATA_W'(status_reg);
        OFS_IRQMASK: rdata_next = DATA_W'(irqMask_reg);
        OFS_VECTOR: rdata_next = DATA_W'(vector_reg);
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      resp_reg <= resp_next;
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software registers, vector capture and sticky status
  always_comb begin
    vecBase_next = vecBase_reg;
    mask_next = mask_reg;
    cfgDir_next = cfgDir_reg;
    irqMask_next = irqMask_reg;
    vector_next = vector_reg;
    status_next = status_reg;
    if (wrDone) begin
      case (address)
        OFS_VECBASE: vecBase_next = writedata[BASE_W-1:0];
        OFS_MASK: mask_next = writedata[MASK_W-1:0];
        OFS_CONFIG: cfgDir_next = writedata[CFG_DIR_BIT];
        OFS_IRQMASK: irqMask_next = writedata[SRC_N-1:0];
        default: ;
      endcase
    end
    if (rdDone && address == OFS_STATUS) begin
      status_next = '0;
    end
    if (accept) begin
      vector_next = {vecBase_reg, VEC_GAP, selAddr};
      // set after clear so a same-cycle event survives the read
      status_next = status_next | grant;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vecBase_reg <= RST_VECBASE;
      mask_reg <= RST_MASK;
      cfgDir_reg <= RST_CFG_DIR;
      irqMask_reg <= RST_IRQMASK;
      vector_reg <= RST_VECTOR;
      status_reg <= RST_STATUS;
    end else begin
      vecBase_reg <= vecBase_next;
      mask_reg <= mask_next;
      cfgDir_reg <= cfgDir_next;
      irqMask_reg <= irqMask_next;
      vector_reg <= vector_next;
      status_reg <= status_next;
    end
  end

  // pin level is the mask bit itself while configured as output
  assign bidirIrqOut = mask_reg[SRC_BIDIR];
  assign bidirIrqOe = cfgDir_reg;
  assign vectorOut = vector_reg;
  assign irq = |(status_reg & irqMask_reg);

  //////////////////////////////////////////////////////////////////////////
  // checks
  vec_form_a: assert property (
    @(posedge clk) disable iff (rst)
    accept |=> vectorOut[15:8] == $past(vecBase_reg) && vectorOut[7:6] == 2'h0)
    else $error("vector base or gap wrong");

  vec_rx_a: assert property (
    @(posedge clk) disable iff (rst)
    intAck && rxReq && !mask_reg[0] && !nmiReq |=> vectorOut[5:0] == 6'h04)
    else $error("receiver vector wrong");

  vec_nmi_a: assert property (
    @(posedge clk) disable iff (rst)
    intAck && nmiReq |=> vectorOut[5:0] == 6'h1C && status_reg[5])
    else $error("nmi vector wrong");

  vec_timer_a: assert property (
    @(posedge clk) disable iff (rst)
    intAck && timerReq && mask_reg[3:0] == 4'hF && !nmiReq
    |=> vectorOut[5:0] == 6'h14)
    else $error("timer vector wrong");

  prio_tx_a: assert property (
    @(posedge clk) disable iff (rst)
    intAck && txReq && turnReq && !mask_reg[1] && (mask_reg[0] || !rxReq)
    && !nmiReq |=> vectorOut[5:0] == 6'h08)
    else $error("transmitter priority wrong");

  mask_all_a: assert property (
    @(posedge clk) disable iff (rst)
    mask_reg == 5'h1F && !nmiReq |-> !irqPending)
    else $error("masked source requested");

  pin_drive_a: assert property (
    @(posedge clk) disable iff (rst)
    wrDone && address == OFS_MASK && cfgDir_reg
    |=> bidirIrqOe && bidirIrqOut == $past(writedata[3]))
    else $error("pin not driven from mask bit");

  pin_mask_a: assert property (
    @(posedge clk) disable iff (rst)
    accept && mask_reg[3] |=> vectorOut[5:0] != 6'h10)
    else $error("masked pin source taken");

  nmi_pend_a: assert property (
    @(posedge clk) disable iff (rst)
    nmiReq |-> irqPending)
    else $error("nmi not pending");

  bus_wait_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(read) && !resp_reg |-> waitrequest ##1 !waitrequest)
    else $error("read answer not after one wait");

endmodule

// ==== test/core_model.sv ====
// behavioural processor core that takes interrupt vectors
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irqPending,
  input wire logic [ivmu_pkg::VEC_W-1:0] vectorOut,
  input wire logic go,
  input wire logic slow,
  output logic intAck,
  output logic done,
  output logic [ivmu_pkg::VEC_W-1:0] gotVec
);
  logic armed;
  logic [2:0] cnt;
  logic [1:0] stage;
  //////////////////////////////////////////////////////////////////////
  // one accept per go; a slow core lets the request wait five cycles
  always_ff @(posedge clk) begin
    intAck <= 1'b0;
    done <= 1'b0;
    if (rst) begin
      armed <= 1'b0;
      stage <= 2'h0;
    end else if (stage == 2'h1) begin
      stage <= 2'h2;
    end else if (stage == 2'h2) begin
      stage <= 2'h0;
      gotVec <= vectorOut;
      done <= 1'b1;
    end else if (go) begin
      armed <= 1'b1;
      cnt <= slow ? 3'h5 : 3'h0;
    end else if (armed && irqPending) begin
      if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else begin
        intAck <= 1'b1;
        armed <= 1'b0;
        stage <= 2'h1;
      end
    end
  end
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the interrupt vector and mask unit
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  miscompares++; $display("mismatch %0t got %h exp %h", $time, a, e); end end
module testbench;
  import ivmu_pkg::*;
  localparam logic [5:0] VA [6] = '{6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h1C};
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic go = 1'b0, slow = 1'b0, waitrequest, pinLevel, bidirIrqOut;
  logic bidirIrqOe, irqPending, intAck, irq, done;
  logic [ADDR_W-1:0] address = '0;
  logic [DATA_W-1:0] writedata = '0, readdata, rd;
  logic [5:0] src = 6'h00;
  logic [VEC_W-1:0] vectorOut, gotVec;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  // pin wire: the unit's level when it drives, else the outside source
  assign pinLevel = bidirIrqOe ? bidirIrqOut : src[3];
  interrupt_vector_mask_unit u_interrupt_vector_mask_unit (.clk, .rst,
    .address, .read, .write, .writedata, .readdata, .waitrequest,
    .rxReq(src[0]), .txReq(src[1]), .turnReq(src[2]), .timerReq(src[4]),
    .nmiReq(src[5]), .bidirIrqIn(pinLevel), .bidirIrqOut, .bidirIrqOe,
    .irqPending, .intAck, .vectorOut, .irq);
  core_model u_core_model (.clk, .rst, .irqPending, .vectorOut, .go,
    .slow, .intAck, .done, .gotVec);
  initial begin
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    // only the cycle ceiling below ends a stalled access
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // core takes one vector, then the serviced sources drop their request
  task automatic take(input logic [5:0] v, input logic s,
      input logic [5:0] clr);
    @(posedge clk);
    go <= 1'b1;
    slow <= s;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
    end while (done !== 1'b1);
    `CHK(gotVec, {8'hA5, 2'h0, v})
    src <= src & ~clr;
    repeat (4) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  // a hang is cut short after far more cycles than the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, OFS_VECBASE, 32'h000000A5);
    bus(1'b0, OFS_VECBASE, '0);
    `CHK(rd, 32'h000000A5)
    bus(1'b0, 5'h1C, '0);
    `CHK(rd, 32'h00000000)
    // each source alone, prompt and slow core in turn
    for (int i = 0; i < 6; i++) begin
      src <= 6'h01 << i;
      take(VA[i], i[0], 6'h01 << i);
    end
    // vector register keeps the last accept; writes to it are ignored
    bus(1'b1, OFS_VECTOR, 32'h00001234);
    bus(1'b0, OFS_VECTOR, '0);
    `CHK(rd, 32'h0000A51C)
    bus(1'b1, OFS_MASK, 32'h0000001F);
    bus(1'b0, OFS_MASK, '0);
    `CHK(rd, 32'h0000001F)
    src <= 6'h3F;
    take(VA[5], 1'b0, 6'h20);
    `CHK(irqPending, 1'b0)
    bus(1'b1, OFS_MASK, 32'h00000000);
    for (int i = 0; i < 5; i++) take(VA[i], 1'b0, 6'h01 << i);
    // all but one source masked, so only that one may be taken
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_MASK, ~(32'h1 << i) & 32'h1F);
      src <= 6'h1F;
      take(VA[i], 1'b0, 6'h1F);
    end
    bus(1'b1, OFS_CONFIG, 32'h1);
    bus(1'b0, OFS_CONFIG, '0);
    `CHK(rd, 32'h00000001)
    bus(1'b1, OFS_MASK, 32'h8);
    repeat (4) @(posedge clk);
    `CHK({bidirIrqOe, bidirIrqOut, irqPending}, 3'h6)
    bus(1'b1, OFS_MASK, 32'h0);
    @(posedge clk);
    `CHK(bidirIrqOut, 1'b0)
    bus(1'b1, OFS_CONFIG, 32'h0);
    // status, irq mask and level output; status ignores writes
    bus(1'b1, OFS_STATUS, 32'h0);
    bus(1'b0, OFS_STATUS, '0);
    `CHK(rd, 32'h0000003F)
    bus(1'b1, OFS_IRQMASK, 32'h1);
    src <= 6'h01;
    take(VA[0], 1'b0, 6'h01);
    `CHK(irq, 1'b1)
    bus(1'b0, OFS_STATUS, '0);
    `CHK(rd, 32'h1)
    @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1'b1, OFS_IRQMASK, 32'h0);
    src <= 6'h02;
    take(VA[1], 1'b1, 6'h02);
    `CHK(irq, 1'b0)
    bus(1'b1, OFS_IRQMASK, 32'h2);
    @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1'b0, OFS_IRQMASK, '0);
    `CHK(rd, 32'h00000002)
    wrap_up();
  end
endmodule
